/* rtl/ptr_mask_pkg.sv */
// Purpose: Constants for the pointer-mask address transform stage
// Assumes: 64-bit hart, Avalon-MM register access
// Notes:   Register offsets are byte addresses of 32-bit words
package ptr_mask_pkg;
    localparam int unsigned ADDR_W          = 64;
    localparam int unsigned MASK_LONG       = 16;
    localparam int unsigned MASK_SHORT      = 7;
    localparam logic [1:0]  MODE_OFF        = 2'h0;
    localparam logic [1:0]  MODE_RSVD       = 2'h1;
    localparam logic [1:0]  MODE_SHORT      = 2'h2;
    localparam logic [1:0]  MODE_LONG       = 2'h3;
    localparam logic [1:0]  PRIV_U          = 2'h0;
    localparam logic [1:0]  PRIV_S          = 2'h1;
    localparam logic [1:0]  PRIV_M          = 2'h3;
    localparam logic [3:0]  OFS_MODE_CFG    = 4'h0;
    localparam logic [3:0]  OFS_STATUS      = 4'h4;
    localparam logic [3:0]  OFS_TRAPVAL_LO  = 4'h8;
    localparam logic [3:0]  OFS_TRAPVAL_HI  = 4'hC;
    localparam int unsigned CFG_U_LSB       = 0;
    localparam int unsigned CFG_S_LSB       = 2;
    localparam int unsigned CFG_M_LSB       = 4;
    localparam logic [5:0]  CFG_RESET       = 6'h00;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;

    typedef enum logic [2:0] {
        ACC_LOAD   = 3'b000,
        ACC_STORE  = 3'b001,
        ACC_AMO    = 3'b010,
        ACC_CBO    = 3'b011,
        ACC_VEC    = 3'b100,
        ACC_SSTACK = 3'b101,
        ACC_FENCE  = 3'b110,
        ACC_IMPL   = 3'b111
    } acc_kind_e;
endpackage : ptr_mask_pkg

/* rtl/ptr_mask_unit.sv */
// Purpose: Strip tag bits from explicit data-access effective addresses
// Assumes: Access inputs come from same-clock pipeline logic
// Notes:   One registered stage on every path; unmasked paths match latency
`timescale 1ns/1ps

// How it works
// - Only sixteen or seven bit masks exist
// - Separate setting per privilege, applied automatically
// - Setting held in higher-level configuration register
// - Setting chosen by privilege, never address bits
// - All explicit data accesses are masked
// - Translation fence operands pass unmasked
// - Redirected effective privilege picks the setting
// - Executable-readable override disables masking entirely
// - Cache-block operations use the masked address
// - Walks and other bus masters bypass masking
// - Misaligned pieces each masked, same bytes
// - Software register accesses store values unmasked
// - Address register width independent of masking
// - Hardware-written trap value is masked
// - Debug trigger compares masked address
// - Trap vector used exactly as written
// - Bit below mask field is sign source
// - Virtual addresses sign-extend masked upper bits
// - Physical addresses zero the masked bits
// - Mode field 00 off, 10 seven, 11 sixteen
module ptr_mask_unit
    import ptr_mask_pkg::*;
#(
    parameter int unsigned AW = ADDR_W
)(
    input  wire logic          sys_clk_i,
    input  wire logic          rstn_i,
    // Access request from load/store, atomic, vector and cache-op units
    input  wire logic          acc_valid_i,
    input  wire logic [2:0]    acc_kind_i,
    input  wire logic [AW-1:0] acc_addr_i,
    input  wire logic [1:0]    priv_i,
    input  wire logic          modify_privilege_ctl_i,
    input  wire logic          guest_access_privilege_ctl_i,
    input  wire logic [1:0]    eff_priv_i,
    input  wire logic          exec_readable_override_i,
    input  wire logic          virt_mode_i,
    input  wire logic          fault_i,
    input  wire logic [AW-1:0] trap_vector_i,
    input  wire logic          trap_take_i,
    input  wire logic [AW-1:0] trigger_addr_i,
    // Avalon-MM slave
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    // Toward translation and memory
    output logic               xlat_valid_o,
    output logic [AW-1:0]      xlat_addr_o,
    output logic [2:0]         xlat_kind_o,
    output logic               trig_hit_o,
    output logic               trapval_we_o,
    output logic [AW-1:0]      trapval_o,
    output logic               trap_pc_we_o,
    output logic [AW-1:0]      trap_pc_o
);

    typedef struct packed {
        logic [5:0]    cfg;
        logic          xlat_valid;
        logic [AW-1:0] xlat_addr;
        logic [2:0]    xlat_kind;
        logic          trig_hit;
        logic          trapval_we;
        logic [AW-1:0] trapval;
        logic          trap_pc_we;
        logic [AW-1:0] trap_pc;
        logic [1:0]    last_len;
        logic [31:0]   rdata;
        logic          wreq;
    } state_s;

    state_s st_q;
    state_s st_d;
    logic   rst_n;

    // Released reset stage, separate so the rest resets from its copy
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    localparam int unsigned CFG_LEVELS = 3;

    logic [1:0]    sel_priv;
    logic [1:0]    sel_mode;
    logic          exempt;
    logic          use_long;
    logic          use_short;
    logic          sign_src;
    logic          fill_bit;
    logic [AW-1:0] repl_bit;
    logic [AW-1:0] masked;
    logic          bus_req;
    logic          cfg_hit;
    logic [5:0]    cfg_wr;

    // Setting selection; address bits never feed this choice
    always_comb
    begin
        // Redirected privilege wins for data accesses
        if (modify_privilege_ctl_i || guest_access_privilege_ctl_i)
        begin
            sel_priv = eff_priv_i;
        end
        else
        begin
            sel_priv = priv_i;
        end
        unique case (sel_priv)
            PRIV_U:  sel_mode = st_q.cfg[CFG_U_LSB +: 2];
            PRIV_S:  sel_mode = st_q.cfg[CFG_S_LSB +: 2];
            PRIV_M:  sel_mode = st_q.cfg[CFG_M_LSB +: 2];
            default: sel_mode = MODE_OFF;
        endcase
        exempt = exec_readable_override_i
              || (acc_kind_i == ACC_FENCE)
              || (acc_kind_i == ACC_IMPL);
        // Reserved code never reaches the mask: treated as off
        use_long  = !exempt && (sel_mode == MODE_LONG);
        use_short = !exempt && (sel_mode == MODE_SHORT);
        if (use_long)
        begin
            sign_src = acc_addr_i[AW-MASK_LONG-1];
        end
        else
        begin
            sign_src = acc_addr_i[AW-MASK_SHORT-1];
        end
        // Physical addresses fill with zero, virtual ones sign-extend
        fill_bit = virt_mode_i && sign_src;

        // Avalon: first cycle raises the answer, second one completes
        bus_req = (avs_read || avs_write) && st_q.wreq;
        cfg_hit = avs_write && !st_q.wreq
               && (avs_address == OFS_MODE_CFG) && avs_byteenable[0];
    end

    // Only the top bits can change, so per-byte masking of a misaligned
    // access touches the same bytes as masking its base address
    for (genvar b = 0; b < AW; b++)
    begin : g_bit
        localparam bit IN_LONG  = (b >= int'(AW - MASK_LONG));
        localparam bit IN_SHORT = (b >= int'(AW - MASK_SHORT));
        assign repl_bit[b] = (use_long && IN_LONG) || (use_short && IN_SHORT);
        assign masked[b]   = repl_bit[b] ? fill_bit : acc_addr_i[b];
    end

    // Per-level update; a reserved code keeps that level's old value
    for (genvar l = 0; l < CFG_LEVELS; l++)
    begin : g_lvl
        logic [1:0] wr_code;
        assign wr_code          = avs_writedata[2*l +: 2];
        assign cfg_wr[2*l +: 2] = (cfg_hit && (wr_code != MODE_RSVD)) ? wr_code
                                                                      : st_q.cfg[2*l +: 2];
    end

    always_comb
    begin
        st_d            = st_q;
        st_d.xlat_valid = acc_valid_i;
        st_d.xlat_addr  = masked;
        st_d.xlat_kind  = acc_kind_i;
        st_d.trig_hit   = acc_valid_i && (masked == trigger_addr_i);
        st_d.trapval_we = acc_valid_i && fault_i;
        if (acc_valid_i && fault_i)
        begin
            st_d.trapval = masked;
        end
        st_d.trap_pc_we = trap_take_i;
        if (trap_take_i)
        begin
            st_d.trap_pc = trap_vector_i;
        end
        if (acc_valid_i && !exempt)
        begin
            st_d.last_len = sel_mode;
        end

        // Write lands on the edge where waitrequest is seen low
        st_d.cfg  = cfg_wr;
        st_d.wreq = !bus_req;
        if (bus_req && avs_read)
        begin
            unique case (avs_address)
                OFS_MODE_CFG:   st_d.rdata = {26'h0, st_q.cfg};
                OFS_STATUS:     st_d.rdata = {30'h0, st_q.last_len};
                OFS_TRAPVAL_LO: st_d.rdata = st_q.trapval[31:0];
                OFS_TRAPVAL_HI: st_d.rdata = st_q.trapval[63:32];
                default:        st_d.rdata = UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_q      <= '0;
            st_q.cfg  <= CFG_RESET;
            st_q.wreq <= 1'b1;
        end
        else if (!rst_n)
        begin
            st_q      <= '0;
            st_q.cfg  <= CFG_RESET;
            st_q.wreq <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign avs_readdata    = st_q.rdata;
    assign avs_waitrequest = st_q.wreq;
    assign xlat_valid_o    = st_q.xlat_valid;
    assign xlat_addr_o     = st_q.xlat_addr;
    assign xlat_kind_o     = st_q.xlat_kind;
    assign trig_hit_o      = st_q.trig_hit;
    assign trapval_we_o    = st_q.trapval_we;
    assign trapval_o       = st_q.trapval;
    assign trap_pc_we_o    = st_q.trap_pc_we;
    assign trap_pc_o       = st_q.trap_pc;

endmodule : ptr_mask_unit

/* tb/ptr_mask_props.sv */
// Purpose: Port-level properties of the address mask stage
// Assumes: One clock, active-low asynchronous reset
// Notes:   Bound onto every instance of the stage
`timescale 1ns/1ps
module ptr_mask_props
    import ptr_mask_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    input wire logic        acc_valid_i,
    input wire logic [2:0]  acc_kind_i,
    input wire logic [63:0] acc_addr_i,
    input wire logic        exec_readable_override_i,
    input wire logic        trap_take_i,
    input wire logic [63:0] trap_vector_i,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        xlat_valid_o,
    input wire logic [63:0] xlat_addr_o,
    input wire logic [2:0]  xlat_kind_o,
    input wire logic        trap_pc_we_o,
    input wire logic [63:0] trap_pc_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    AST_LAT: assert property (acc_valid_i |=> xlat_valid_o) else $error("access lost");
    AST_KIND: assert property (acc_valid_i |=> xlat_kind_o == $past(acc_kind_i)) else $error("kind bad");
    AST_EXEMPT: assert property (acc_valid_i && acc_kind_i[2:1] == 2'b11 |=> xlat_addr_o == $past(acc_addr_i))
        else $error("exempt masked");
    AST_MXR: assert property (acc_valid_i && exec_readable_override_i |=> xlat_addr_o == $past(acc_addr_i))
        else $error("override lost");
    AST_LOW: assert property (acc_valid_i |=> xlat_addr_o[47:0] == $past(acc_addr_i[47:0])) else $error("low bad");
    AST_TPC: assert property (trap_take_i |=> trap_pc_we_o && trap_pc_o == $past(trap_vector_i))
        else $error("vector bad");
    AST_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no ack");
    AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack held");
    COV_CBO: cover property (acc_valid_i && acc_kind_i == 3'h3);
    COV_TRAP: cover property (trap_take_i);
    COV_RD: cover property (avs_read && !avs_waitrequest);
endmodule : ptr_mask_props

bind ptr_mask_unit ptr_mask_props props_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .acc_valid_i(acc_valid_i),
    .acc_kind_i(acc_kind_i), .acc_addr_i(acc_addr_i), .exec_readable_override_i(exec_readable_override_i),
    .trap_take_i(trap_take_i), .trap_vector_i(trap_vector_i), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .xlat_valid_o(xlat_valid_o), .xlat_addr_o(xlat_addr_o),
    .xlat_kind_o(xlat_kind_o), .trap_pc_we_o(trap_pc_we_o), .trap_pc_o(trap_pc_o));

/* tb/xlat_sink.sv */
// Purpose: Translation-side model holding the last address
// Assumes: Translation takes one access per cycle
// Notes:   Never stalls; the stage has no backpressure
`timescale 1ns/1ps
module xlat_sink
    import ptr_mask_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        valid_i,
    input  wire logic [63:0] addr_i,
    output logic [63:0]      last_addr_o
);
    always_ff @(posedge sys_clk_i)
        if (valid_i)
            last_addr_o <= addr_i;
endmodule : xlat_sink

/* tb/pointer_mask_address_transform_tb.sv */
// Purpose: Self-checking bench for the pointer mask stage
// Assumes: Master waits for waitrequest low
// Notes:   Expected addresses are built locally
`timescale 1ns/1ps
module pointer_mask_address_transform_tb
    import ptr_mask_pkg::*;
;
    localparam logic [63:0] ADR_A = 64'hA5B6_8000_1234_5678;
    // Top bit differs from both sign sources here
    localparam logic [63:0] ADR_B = 64'hDA49_7F00_1234_5678;
    logic clk = 1'b0, rstn_i = 1'b0, vld = 1'b0, modify_privilege_ctl = 1'b0, gctl = 1'b0, exec_readable_override = 1'b0, virt = 1'b0;
    logic flt = 1'b0, take = 1'b0, rd = 1'b0, wr = 1'b0, wrq, hit, tw, pw, xv;
    logic [2:0]  kind = 3'h0, xk;
    logic [1:0]  priv = 2'h0, ep = 2'h0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, bus_q;
    logic [63:0] va = ADR_A, vec = 64'h0, trig = 64'h0, xa, tv, pc, last;
    int          mismatches = 0, samples_checked = 0;
    always #20 clk = ~clk;
    ptr_mask_unit dut_u (.sys_clk_i(clk), .rstn_i(rstn_i), .acc_valid_i(vld), .acc_kind_i(kind),
        .acc_addr_i(va), .priv_i(priv), .modify_privilege_ctl_i(modify_privilege_ctl), .guest_access_privilege_ctl_i(gctl),
        .eff_priv_i(ep), .exec_readable_override_i(exec_readable_override), .virt_mode_i(virt), .fault_i(flt), .trap_vector_i(vec),
        .trap_take_i(take), .trigger_addr_i(trig), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wrq),
        .xlat_valid_o(xv), .xlat_addr_o(xa), .xlat_kind_o(xk), .trig_hit_o(hit), .trapval_we_o(tw),
        .trapval_o(tv), .trap_pc_we_o(pw), .trap_pc_o(pc));
    xlat_sink sink_u (.sys_clk_i(clk), .valid_i(xv), .addr_i(xa), .last_addr_o(last));
    task check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [63:0] msk(input logic [63:0] a, input int n, input logic v);
        msk = a;
        for (int i = 64 - n; i < 64; i++)
            msk[i] = v & a[63 - n];
    endfunction : msk
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (wrq !== 1'b0)
            @(posedge clk);
        bus_q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic acc(input logic [2:0] k, input logic [1:0] p, input logic v, x, m, g, input logic [1:0] e, int n);
        logic [63:0] exp;
        exp = msk(va, n, v);
        @(posedge clk);
        {vld, kind, priv, virt, exec_readable_override, modify_privilege_ctl, gctl, ep} <= {1'b1, k, p, v, x, m, g, e};
        flt <= (k < 3'h6);
        trig <= exp;
        @(posedge clk);
        flt <= 1'b0;
        trig <= ~exp;
        @(negedge clk);
        check(xk, k);
        check(hit, 1'b1);
        if (k < 3'h6)
        begin
            check(tw, 1'b1);
            check(tv, exp);
        end
        @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        check(hit, 1'b0);
        check(tw, 1'b0);
        check(last, exp);
    endtask : acc
    task t_regs();
        bus(1'b0, OFS_MODE_CFG, 32'h0);
        check(bus_q, 32'h0);
        bus(1'b0, 4'h1, 32'h0);
        check(bus_q, UNMAPPED_DATA);
        bus(1'b1, OFS_MODE_CFG, 32'h0000_000B);
        bus(1'b1, OFS_MODE_CFG, 32'h0000_0009);
        bus(1'b0, OFS_MODE_CFG, 32'h0);
        check(bus_q, 32'h0000_000B);
        $display("test regs done");
    endtask : t_regs
    task t_mask(input logic [63:0] a);
        @(posedge clk);
        va <= a;
        @(negedge clk);
        acc(ACC_LOAD, PRIV_U, 1'b1, 1'b0, 1'b0, 1'b0, PRIV_U, 16);
        acc(ACC_STORE, PRIV_S, 1'b0, 1'b0, 1'b0, 1'b0, PRIV_U, 7);
        acc(ACC_AMO, PRIV_M, 1'b1, 1'b0, 1'b0, 1'b0, PRIV_U, 0);
        acc(ACC_CBO, PRIV_U, 1'b1, 1'b0, 1'b0, 1'b0, PRIV_U, 16);
        acc(ACC_VEC, PRIV_U, 1'b0, 1'b0, 1'b0, 1'b0, PRIV_U, 16);
        acc(ACC_SSTACK, PRIV_S, 1'b1, 1'b0, 1'b0, 1'b0, PRIV_U, 7);
        acc(ACC_FENCE, PRIV_U, 1'b1, 1'b0, 1'b0, 1'b0, PRIV_U, 0);
        acc(ACC_IMPL, PRIV_U, 1'b1, 1'b0, 1'b0, 1'b0, PRIV_U, 0);
        acc(ACC_LOAD, PRIV_U, 1'b1, 1'b1, 1'b0, 1'b0, PRIV_U, 0);
        acc(ACC_STORE, PRIV_M, 1'b1, 1'b0, 1'b1, 1'b0, PRIV_U, 16);
        acc(ACC_LOAD, PRIV_U, 1'b1, 1'b0, 1'b0, 1'b1, PRIV_S, 7);
        bus(1'b0, OFS_STATUS, 32'h0);
        check(bus_q, {30'h0, MODE_SHORT});
        $display("test mask done");
    endtask : t_mask
    task automatic t_trap();
        logic [63:0] t;
        t = msk(va, 7, 1'b1);
        bus(1'b0, OFS_TRAPVAL_LO, 32'h0);
        check(bus_q, t[31:0]);
        bus(1'b0, OFS_TRAPVAL_HI, 32'h0);
        check(bus_q, t[63:32]);
        @(posedge clk);
        vec <= ADR_A;
        take <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        @(negedge clk);
        check(pw, 1'b1);
        check(pc, ADR_A);
        $display("test trap done");
    endtask : t_trap
    task end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (2000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_mask(ADR_A);
        t_mask(ADR_B);
        t_trap();
        end_of_test();
    end
endmodule : pointer_mask_address_transform_tb
